//--- pwg_pkg.sv
package pwg_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [9:0] IDX_PERIOD_LOW  = 10'h0a0;
  localparam logic [9:0] IDX_PERIOD_HIGH = 10'h0a1;
  localparam logic [9:0] IDX_DUTY_LOW    = 10'h0a2;
  localparam logic [9:0] IDX_DUTY_HIGH   = 10'h0a3;
  localparam logic [9:0] IDX_COUNT_LOW   = 10'h0a4;
  localparam logic [9:0] IDX_COUNT_HIGH  = 10'h0a5;
  localparam logic [9:0] IDX_CONTROL0    = 10'h0a6;
  localparam logic [9:0] IDX_CONTROL1    = 10'h0a7;

  // reset values
  localparam logic [15:0] RST_PERIOD   = 16'hffff;
  localparam logic [15:0] RST_DUTY     = 16'h0000;
  localparam logic [15:0] RST_COUNT    = 16'h0000;
  localparam logic [7:0]  RST_CONTROL0 = 8'h00;
  localparam logic        RST_RUN      = 1'b0;
  localparam logic        RST_STATUS   = 1'b0;
  localparam logic        RST_FLAG     = 1'b1;

  // smallest value the period shadow may hold
  localparam logic [15:0] PERIOD_FLOOR = 16'h0001;

  // first control register fields
  localparam int CTL0_CLK_SEL_LSB = 0;
  localparam int CTL0_IRQ_SEL_LSB = 2;
  localparam int CTL0_POLARITY    = 4;

  // second control register fields
  localparam int CTL1_RUN    = 0;
  localparam int CTL1_FLAG   = 6;
  localparam int CTL1_STATUS = 7;

  // count clock select codes
  localparam logic [1:0] CLK_SEL_LOW_SPEED = 2'h0;
  localparam logic [1:0] CLK_SEL_TIMEBASE  = 2'h1;
  localparam logic [1:0] CLK_SEL_EXTERNAL  = 2'h3;

  // pin mode code that selects the modulator as the tertiary function
  localparam logic PIN_MODE_UPPER_PWM = 1'b1;
  localparam logic PIN_MODE_LOWER_PWM = 1'b0;

  typedef enum logic [1:0] {
    IRQ_ON_PERIOD = 2'h0,
    IRQ_ON_DUTY   = 2'h1
  } pwg_irq_sel_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } pwg_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } pwg_wb_rsp_s;

  typedef struct packed {
    logic modeUpper;
    logic modeLower;
    logic portValue;
  } pwg_pin_cfg_s;

endpackage

//--- pwg_pwm_generator.sv
`timescale 1ns/1ps
// Functional notes
// - run set: status on first fall, count second
// - duty match clears flag next fall
// - period match sets flag, counter wraps zero
// - period match loads both shadow values
// - run cleared: one more fall counted, stop
// - restart resumes from retained counter value
// - counter write clears counter, sets flag
// - writes while stopped go straight to shadows
// - output period is period setting plus one
// - duty portion is duty setting plus one
// - first interrupt may slip; later fixed
// - interrupt possible during final stopping count
// - first control picks clock, irq point, polarity
// - pin port value ignored under modulator function
// - clock select codes; code 10 stays inactive
// - irq point: period, duty, or both
// - positive idles high, negative starts low
// - low counter read latches high byte
module pwg_pwm_generator
  import pwg_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire pwg_wb_req_s  wbReq,
  output pwg_wb_rsp_s       wbRsp,
  input  wire logic         lowSpeedClock,
  input  wire logic         highSpeedTimebaseClock,
  input  wire logic         externalClock,
  input  wire pwg_pin_cfg_s firstPinCfg,
  input  wire pwg_pin_cfg_s secondPinCfg,
  output logic              modulatorOutput,
  output logic              firstOutputPin,
  output logic              secondOutputPin,
  output logic              modulatorIrq
);

  // the period shadow never holds zero
  function automatic logic [15:0] periodLoad(input logic [15:0] value);
    periodLoad = (value == 16'h0000) ? PERIOD_FLOOR : value;
  endfunction

  function automatic logic pinIsPwm(input pwg_pin_cfg_s cfg);
    pinIsPwm = (cfg.modeUpper == PIN_MODE_UPPER_PWM) && (cfg.modeLower == PIN_MODE_LOWER_PWM);
  endfunction

  logic [15:0] periodSetting;
  logic [15:0] dutySetting;
  logic [15:0] periodShadow;
  logic [15:0] dutyShadow;
  logic [15:0] counter;
  logic [7:0]  counterHighLatch;
  logic [7:0]  control0;
  logic        runRequest;
  logic        countActiveStatus;
  logic        outputFlag;
  logic        countClock;
  logic        countClockPrev;
  logic        countFall;
  logic        countStep;
  logic        periodMatch;
  logic        dutyMatch;
  logic        irqEvent;
  logic        busReq;
  logic        busWrite;
  logic        busRead;
  logic [9:0]  busIndex;
  logic [7:0]  wrByte;
  logic        wrPeriodLow;
  logic        wrPeriodHigh;
  logic        wrDutyLow;
  logic        wrDutyHigh;
  logic        wrCounter;
  logic        wrControl0;
  logic        wrControl1;
  logic [7:0]  next_rdByte;
  logic [1:0]  clockSelect;
  logic [1:0]  irqSelect;
  logic        negPolarity;

  assign clockSelect = control0[CTL0_CLK_SEL_LSB +: 2];
  assign irqSelect   = control0[CTL0_IRQ_SEL_LSB +: 2];
  assign negPolarity = control0[CTL0_POLARITY];

  // count clock source select
  always_comb
  begin
    countClock = 1'b0;
    if (clockSelect == CLK_SEL_LOW_SPEED)
    begin
      countClock = lowSpeedClock;
    end
    else if (clockSelect == CLK_SEL_TIMEBASE)
    begin
      countClock = highSpeedTimebaseClock;
    end
    else if (clockSelect == CLK_SEL_EXTERNAL)
    begin
      countClock = externalClock;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      countClockPrev <= 1'b0;
    end
    else
    begin
      countClockPrev <= countClock;
    end
  end

  // a source switch may fake one fall; software changes the source while stopped
  assign countFall = countClockPrev && !countClock;
  assign countStep = countFall && countActiveStatus;
  assign periodMatch = countStep && (counter == periodShadow);
  assign dutyMatch   = countStep && (counter == dutyShadow);

  // bus decode; a write takes effect at the edge where ack is seen high
  assign busReq   = wbReq.cyc && wbReq.stb;
  assign busIndex = wbReq.adr[11:2];
  assign busWrite = busReq && wbReq.we && wbRsp.ack && wbReq.sel[0];
  assign busRead  = busReq && !wbReq.we && !wbRsp.ack;
  assign wrByte   = wbReq.dat[7:0];

  assign wrPeriodLow  = busWrite && (busIndex == IDX_PERIOD_LOW);
  assign wrPeriodHigh = busWrite && (busIndex == IDX_PERIOD_HIGH);
  assign wrDutyLow    = busWrite && (busIndex == IDX_DUTY_LOW);
  assign wrDutyHigh   = busWrite && (busIndex == IDX_DUTY_HIGH);
  assign wrCounter    = busWrite && ((busIndex == IDX_COUNT_LOW) || (busIndex == IDX_COUNT_HIGH));
  assign wrControl0   = busWrite && (busIndex == IDX_CONTROL0);
  assign wrControl1   = busWrite && (busIndex == IDX_CONTROL1);

  always_comb
  begin
    next_rdByte = 8'h00;
    if (busIndex == IDX_PERIOD_LOW)
    begin
      next_rdByte = periodSetting[7:0];
    end
    else if (busIndex == IDX_PERIOD_HIGH)
    begin
      next_rdByte = periodSetting[15:8];
    end
    else if (busIndex == IDX_DUTY_LOW)
    begin
      next_rdByte = dutySetting[7:0];
    end
    else if (busIndex == IDX_DUTY_HIGH)
    begin
      next_rdByte = dutySetting[15:8];
    end
    else if (busIndex == IDX_COUNT_LOW)
    begin
      next_rdByte = counter[7:0];
    end
    else if (busIndex == IDX_COUNT_HIGH)
    begin
      next_rdByte = counterHighLatch;
    end
    else if (busIndex == IDX_CONTROL0)
    begin
      next_rdByte = control0;
    end
    else if (busIndex == IDX_CONTROL1)
    begin
      next_rdByte = {countActiveStatus, outputFlag, 5'h00, runRequest};
    end
  end

  // bus answer: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wbRsp <= '0;
    end
    else
    begin
      wbRsp.ack <= busReq && !wbRsp.ack;
      wbRsp.dat <= busRead ? {24'h000000, next_rdByte} : 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      counterHighLatch <= 8'h00;
    end
    else if (busRead && (busIndex == IDX_COUNT_LOW))
    begin
      counterHighLatch <= counter[15:8];
    end
  end

  // settings and control
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      periodSetting <= RST_PERIOD;
      dutySetting   <= RST_DUTY;
      control0      <= RST_CONTROL0;
      runRequest    <= RST_RUN;
    end
    else
    begin
      if (wrPeriodLow)
        periodSetting[7:0] <= wrByte;
      if (wrPeriodHigh)
        periodSetting[15:8] <= wrByte;
      if (wrDutyLow)
        dutySetting[7:0] <= wrByte;
      if (wrDutyHigh)
        dutySetting[15:8] <= wrByte;
      if (wrControl0)
        control0 <= wrByte;
      if (wrControl1)
        runRequest <= wrByte[CTL1_RUN];
    end
  end

  // shadows: straight through while stopped, else loaded at the period match
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      periodShadow <= RST_PERIOD;
      dutyShadow   <= RST_DUTY;
    end
    else if (!countActiveStatus)
    begin
      if (wrPeriodLow)
      begin
        periodShadow <= periodLoad({periodSetting[15:8], wrByte});
      end
      else if (wrPeriodHigh)
      begin
        periodShadow <= periodLoad({wrByte, periodSetting[7:0]});
      end
      if (wrDutyLow)
      begin
        dutyShadow <= {dutySetting[15:8], wrByte};
      end
      else if (wrDutyHigh)
      begin
        dutyShadow <= {wrByte, dutySetting[7:0]};
      end
    end
    else if (periodMatch)
    begin
      periodShadow <= periodLoad(periodSetting);
      dutyShadow   <= dutySetting;
    end
  end

  // status: armed by the first fall after run, dropped by the fall after run clears
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      countActiveStatus <= RST_STATUS;
    end
    else if (countFall)
    begin
      if (!countActiveStatus && runRequest)
      begin
        countActiveStatus <= 1'b1;
      end
      else if (countActiveStatus && !runRequest)
      begin
        countActiveStatus <= 1'b0;
      end
    end
  end

  // counter; a bus write outranks a fall in the same cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      counter <= RST_COUNT;
    end
    else if (wrCounter || periodMatch)
    begin
      counter <= 16'h0000;
    end
    else if (countStep)
    begin
      counter <= counter + 16'h0001;
    end
  end

  // output flag; hardware events outrank a software write to the flag bit
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      outputFlag <= RST_FLAG;
    end
    else if (wrCounter || periodMatch)
    begin
      outputFlag <= 1'b1;
    end
    else if (dutyMatch)
    begin
      outputFlag <= 1'b0;
    end
    else if (wrControl1)
    begin
      outputFlag <= wrByte[CTL1_FLAG];
    end
  end

  assign irqEvent = irqSelect[1] ? (periodMatch || dutyMatch)
                  : ((irqSelect == IRQ_ON_DUTY) ? dutyMatch : periodMatch);

  // matches still count during the final stopping step, so an irq may follow
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      modulatorIrq <= 1'b0;
    end
    else
    begin
      modulatorIrq <= irqEvent;
    end
  end

  // pins
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      modulatorOutput <= RST_FLAG;
      firstOutputPin  <= 1'b0;
      secondOutputPin <= 1'b0;
    end
    else
    begin
      modulatorOutput <= outputFlag ^ negPolarity;
      firstOutputPin  <= pinIsPwm(firstPinCfg) ? (outputFlag ^ negPolarity)
                                                : firstPinCfg.portValue;
      secondOutputPin <= pinIsPwm(secondPinCfg) ? (outputFlag ^ negPolarity)
                                                 : secondPinCfg.portValue;
    end
  end

endmodule

//--- pwg_chk.sv
`timescale 1ns/1ps
module pwg_chk
  import pwg_pkg::*;
(
  input wire logic         clk,
  input wire logic         arst_n,
  input wire pwg_wb_req_s  wbReq,
  input wire pwg_wb_rsp_s  wbRsp,
  input wire logic         lowSpeedClock,
  input wire logic         highSpeedTimebaseClock,
  input wire logic         externalClock,
  input wire pwg_pin_cfg_s firstPinCfg,
  input wire pwg_pin_cfg_s secondPinCfg,
  input wire logic         modulatorOutput,
  input wire logic         firstOutputPin,
  input wire logic         secondOutputPin,
  input wire logic         modulatorIrq
);
  logic [2:0] srcQ;
  logic [3:0] quiet;
  wire  [2:0] src  = {lowSpeedClock, highSpeedTimebaseClock, externalClock};
  wire        pwm1 = firstPinCfg.modeUpper & ~firstPinCfg.modeLower;
  wire        pwm2 = secondPinCfg.modeUpper & ~secondPinCfg.modeLower;

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      srcQ <= 3'h0;
    else
      srcQ <= src;

  // cycles since any count clock fall or bus ack; outputs may only move shortly after one
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      quiet <= 4'hf;
    else if ((|(srcQ & ~src)) || wbRsp.ack)
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  ack_pulse_a: assert property (wbRsp.ack |=> !wbRsp.ack)
    else $error("ack held two cycles");
  ack_cause_a: assert property (wbRsp.ack |-> $past(wbReq.cyc && wbReq.stb))
    else $error("ack without request");
  rdat_idle_a: assert property (!wbRsp.ack |-> wbRsp.dat == 32'h0)
    else $error("read data without ack");
  irq_pulse_a: assert property (modulatorIrq |=> !modulatorIrq)
    else $error("irq longer than one cycle");
  irq_cause_a: assert property (modulatorIrq |-> quiet < 4'h8)
    else $error("irq without count clock fall");
  out_cause_a: assert property ($changed(modulatorOutput) |-> quiet < 4'h8)
    else $error("output moved without cause");
  pin_pwm_a: assert property (pwm1 [*2] |-> firstOutputPin == modulatorOutput)
    else $error("first pin not following modulator");
  pin_port_a: assert property (!pwm2 [*2] |-> secondOutputPin == $past(secondPinCfg.portValue))
    else $error("second pin not following port value");
  pin_pwm2_a: assert property (pwm2 [*2] |-> secondOutputPin == modulatorOutput)
    else $error("second pin not following modulator");

  cover property (wbRsp.ack && !wbReq.we);
  cover property (modulatorIrq);
  cover property ($fell(modulatorOutput));
endmodule

bind pwg_pwm_generator pwg_chk pwg_chk_inst (
  .clk(clk), .arst_n(arst_n), .wbReq(wbReq), .wbRsp(wbRsp),
  .lowSpeedClock(lowSpeedClock), .highSpeedTimebaseClock(highSpeedTimebaseClock),
  .externalClock(externalClock), .firstPinCfg(firstPinCfg),
  .secondPinCfg(secondPinCfg), .modulatorOutput(modulatorOutput),
  .firstOutputPin(firstOutputPin), .secondOutputPin(secondOutputPin),
  .modulatorIrq(modulatorIrq));

//--- pwg_load.sv
`timescale 1ns/1ps
module pwg_load (
  input  wire logic clk,
  input  wire logic pinLevel,
  output int        highLen,
  output int        periodLen,
  output int        rises
);
  int   run = 0;
  int   hi = 0;
  logic last = 1'b1;

  // measures the pin in system clocks: rise to rise, and rise to fall
  always @(posedge clk)
  begin
    last <= pinLevel;
    run <= (pinLevel && !last) ? 1 : run + 1;
    hi <= pinLevel ? hi + 1 : 0;
    if (pinLevel && !last)
      periodLen <= run;
    if (pinLevel && !last)
      rises <= rises + 1;
    if (!pinLevel && last)
      highLen <= hi;
  end
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    total_checks++; \
    if ((a) !== (e)) \
    begin \
      err_total++; \
      $display("[ERR] %0t got %h expected %h", $time, a, e); \
    end \
  end
module tb_top
  import pwg_pkg::*;
;
  logic         clk;
  logic         arst_n = 1'b0;
  logic         lowSpeedClock = 1'b0, highSpeedTimebaseClock = 1'b0, externalClock = 1'b0;
  pwg_wb_req_s  wbReq = '0;
  pwg_wb_rsp_s  wbRsp;
  pwg_pin_cfg_s firstPinCfg = 3'h4, secondPinCfg = 3'h0;
  logic         modulatorOutput, firstOutputPin, secondOutputPin, modulatorIrq;
  int           err_total = 0, total_checks = 0, tick = 0;
  int           highLen, periodLen, rises, pv, dv, n, k;
  logic [7:0]   r, c;
  logic [7:0]   rv[9] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
  int           ck[4] = '{8, 6, 0, 10};
  int           sv[3] = '{0, 1, 3};

  pwg_pwm_generator pwg_pwm_generator_inst (
    .clk(clk), .arst_n(arst_n), .wbReq(wbReq), .wbRsp(wbRsp),
    .lowSpeedClock(lowSpeedClock), .highSpeedTimebaseClock(highSpeedTimebaseClock),
    .externalClock(externalClock), .firstPinCfg(firstPinCfg),
    .secondPinCfg(secondPinCfg), .modulatorOutput(modulatorOutput),
    .firstOutputPin(firstOutputPin), .secondOutputPin(secondOutputPin),
    .modulatorIrq(modulatorIrq));

  pwg_load pwg_load_inst (
    .clk(clk), .pinLevel(firstOutputPin), .highLen(highLen),
    .periodLen(periodLen), .rises(rises));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // first pin stays routed to the modulator so the load can measure it
  always @(posedge clk)
  begin
    tick <= tick + 1;
    lowSpeedClock <= (tick % 8) < 4;
    highSpeedTimebaseClock <= (tick % 6) < 3;
    externalClock <= (tick % 10) < 5;
    firstPinCfg <= {2'b10, 1'($urandom)};
    secondPinCfg <= 3'($urandom);
    if (tick > 20000)
    begin
      err_total++;
      close_out();
    end
  end

  task automatic wb(input logic we, input logic [9:0] idx, input logic [7:0] d);
    wbReq <= '{1'b1, 1'b1, we, {idx, 2'h0}, 4'h1, {24'h0, d}};
    @(posedge clk);
    while (wbRsp.ack !== 1'b1 && tick < 20000)
      @(posedge clk);
    r = wbRsp.dat[7:0];
    wbReq <= '0;
    @(posedge clk);
  endtask

  task automatic wait_rises(input int m);
    int r0;
    r0 = rises;
    while (rises < r0 + m)
      @(posedge clk);
  endtask

  task automatic halt();
    int w;
    w = 0;
    wb(0, IDX_CONTROL1, 8'h00);
    wb(1, IDX_CONTROL1, r & 8'h40);
    do
    begin
      wb(0, IDX_CONTROL1, 8'h00);
      w++;
    end while (r[7] !== 1'b0 && w < 20);
    `CHK(r[7], 1'b0)
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    void'($urandom(25));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    wb(1, 10'h0a8, 8'hff);
    for (int i = 0; i < 9; i++)
    begin
      wb(0, IDX_PERIOD_LOW + 10'(i), 8'h00);
      `CHK(r, rv[i])
    end
    $display("test 1 done");
    wb(1, IDX_PERIOD_HIGH, 8'h00);
    for (int s = 0; s < 3; s++)
    begin
      pv = 2 + $urandom % 6;
      dv = $urandom % pv;
      wb(1, IDX_PERIOD_LOW, 8'(pv));
      wb(1, IDX_DUTY_LOW, 8'(dv));
      wb(1, IDX_CONTROL0, 8'(sv[s]));
      if (s == 0)
        wb(1, IDX_CONTROL1, 8'h41);
      wait_rises(3);
      `CHK(periodLen, (pv + 1) * ck[sv[s]])
      `CHK(highLen, (dv + 1) * ck[sv[s]])
    end
    $display("test 2 done");
    for (int m = 0; m < 3; m++)
    begin
      wb(1, IDX_CONTROL0, 8'(m << 2));
      wait_rises(1);
      n = 0;
      k = rises;
      while (rises == k)
      begin
        @(posedge clk);
        n += int'(modulatorIrq);
      end
      `CHK(n, (m == 2) ? 2 : 1)
    end
    $display("test 3 done");
    halt();
    wb(0, IDX_COUNT_LOW, 8'h00);
    c = r;
    repeat (40) @(posedge clk);
    wb(0, IDX_COUNT_LOW, 8'h00);
    `CHK(r, c)
    wb(1, IDX_CONTROL1, 8'h41);
    wb(0, IDX_COUNT_LOW, 8'h00);
    `CHK(r, c)
    k = 0;
    do
    begin
      wb(0, IDX_CONTROL1, 8'h00);
      k++;
    end while (r[7] !== 1'b1 && k < 20);
    `CHK(r[7], 1'b1)
    $display("test 4 done");
    halt();
    wb(1, IDX_COUNT_HIGH, 8'($urandom));
    wb(0, IDX_COUNT_LOW, 8'h00);
    `CHK(r, 8'h00)
    wb(0, IDX_CONTROL1, 8'h00);
    `CHK(r[6], 1'b1)
    `CHK(modulatorOutput, 1'b1)
    wb(1, IDX_CONTROL0, 8'h12);
    @(posedge clk);
    `CHK(modulatorOutput, 1'b0)
    wb(1, IDX_CONTROL1, 8'h01);
    repeat (2) @(posedge clk);
    `CHK(modulatorOutput, 1'b1)
    repeat (60) @(posedge clk);
    wb(0, IDX_CONTROL1, 8'h00);
    `CHK(r[7], 1'b0)
    $display("test 5 done");
    close_out();
  end
endmodule
